//--- core/conditional_branch_unit.sv
// Branch resolution for an 8-bit core: tests status flags and
// produces the next program counter for conditional relative branches.
// Assumes requests, flags and PC come from logic on mclk, so no
// synchronisers; the core holds off new requests while busy_q is high.
// The unit never writes a flag: the core's status register stays the
// only owner, and sreg_out_q is a plain echo for its write-back path.
// A request that arrives while busy_q is high is dropped, not queued;
// queueing would cost a buffer that the core has no use for.
module conditional_branch_unit
  import branch_pkg::*;
#(
  parameter int PC_W = PC_W_DEF,
  parameter int K_W  = K_W_DEF
)(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              req,
  input  wire branch_op_t        op,
  input  wire logic [K_W-1:0]    offset,
  input  wire logic [PC_W-1:0]   pc,
  input  wire logic [7:0]        sreg,
  input  wire logic              flag_c,
  input  wire logic              flag_n,
  input  wire logic              flag_v,
  output logic                   busy_q,
  output logic                   done_q,
  output logic                   taken_q,
  output logic                   illegal_q,
  output logic                   pc_load_q,
  output logic [PC_W-1:0]        pc_next_q,
  output logic [1:0]             cycles_q,
  output logic [7:0]             sreg_out_q
);

  // ==========================================================
  // Elaboration checks
  // The offset must be narrower than the PC so sign extension is real
  if (K_W < 2 || K_W >= PC_W) begin : g_bad_k
    $error("offset width must be 2 or more and below PC width");
  end
  if (PC_W > 32) begin : g_bad_pc
    $error("PC width above 32 is not supported");
  end
  // Cycle counts feed the core's stall logic; a taken branch must
  // report the longer count or the stall would release too early
  if (CYC_TAKEN <= CYC_NOT_TAKEN) begin : g_bad_cyc
    $error("taken cycle count must exceed the not-taken count");
  end

  // ==========================================================
  // Arithmetic helpers
  // Sign-extend the relative offset to the PC width
  // The top offset bit carries the sign; backward branches wrap
  function automatic logic [PC_W-1:0] sext(input logic [K_W-1:0] k);
    sext = {{(PC_W-K_W){k[K_W-1]}}, k};
  endfunction

  // Add a displacement and the one-word step; wraps like the PC does
  function automatic logic [PC_W-1:0] step(input logic [PC_W-1:0] base,
                                           input logic [PC_W-1:0] disp);
    logic [PC_W-1:0] one;
    one  = {{(PC_W-1){1'b0}}, 1'b1};
    step = base + disp + one;
  endfunction

  // ==========================================================
  // Condition evaluation
  logic take;
  logic legal;

  branch_cond_eval u_cond (
    .op     (op),
    .flag_c (flag_c),
    .flag_n (flag_n),
    .flag_v (flag_v),
    .take   (take),
    .legal  (legal)
  );

  // ==========================================================
  // Controller
  branch_state_t   state_q;
  branch_state_t   state_d;
  logic            accept;
  logic [PC_W-1:0] target_q;

  // Requests are only seen in idle; a request during the jump cycle
  // is dropped, since the core is stalled there anyway
  assign accept = req && (state_q == st_idle);

  // One decode of the outcomes, shared by every register below but the status echo, so
  // that the state, the target and the outputs can never disagree
  logic start_jump;
  logic finish_short;
  logic in_jump;

  // Taken: spend the extra cycle before the PC is loaded
  assign start_jump   = accept && legal && take;
  // Not taken, or an unused selector: done in a single cycle
  assign finish_short = accept && !(legal && take);
  // Second cycle of a taken branch
  assign in_jump      = (state_q == st_jump);

  // Next-state logic: a taken branch spends one extra cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (start_jump) begin
          state_d = st_jump;
        end
      end
      st_jump: begin
        state_d = st_idle;
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // Branch target held over into the jump cycle,
  // so the core need not hold pc and offset stable for two cycles
  always_ff @(posedge mclk) begin
    if (srst) begin
      target_q <= '0;
    end else if (start_jump) begin
      target_q <= step(pc, sext(offset));
    end
  end

  // ==========================================================
  // Outputs
  // Busy covers the second cycle of a taken branch only.
  // It mirrors the jump state, registered so the output comes from a
  // flip-flop and not from the next-state decode
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d == st_jump);
    end
  end

  // Completion and unused-selector strobes, one cycle each, so the
  // core sees exactly one completion per accepted request
  always_ff @(posedge mclk) begin
    if (srst) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q    <= in_jump || finish_short;
      illegal_q <= finish_short && !legal;
    end
  end

  // Outcome and cycle count hold until the next completion, so the
  // core may read them late without a capture register of its own
  always_ff @(posedge mclk) begin
    if (srst) begin
      taken_q  <= 1'b0;
      cycles_q <= '0;
    end else if (in_jump) begin
      taken_q  <= 1'b1;
      cycles_q <= CYC_TAKEN;
    end else if (finish_short) begin
      taken_q  <= 1'b0;
      cycles_q <= CYC_NOT_TAKEN;
    end
  end

  // ==========================================================
  // Program counter
  // Not taken falls through to PC+1, so the core can load pc_next_q
  // on every pc_load_q pulse without an adder of its own.
  // The load pulse always coincides with done_q.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_load_q <= 1'b0;
      pc_next_q <= '0;
    end else begin
      pc_load_q <= in_jump || finish_short;
      if (in_jump) begin
        pc_next_q <= target_q;
      end else if (finish_short) begin
        pc_next_q <= step(pc, '0);
      end
    end
  end

  // ==========================================================
  // Status echo
  // Captured at acceptance and never modified; a request refused in
  // the jump cycle cannot overwrite the byte of the branch in flight
  always_ff @(posedge mclk) begin
    if (srst) begin
      sreg_out_q <= '0;
    end else if (accept) begin
      sreg_out_q <= sreg;
    end
  end

endmodule

//--- core/branch_pkg.sv
// Shared constants and types for the conditional branch unit.
// Assumes a core that presents one branch request per instruction slot.
package branch_pkg;

  // ==========================================================
  // Widths
  localparam int PC_W_DEF = 16;     // Program counter width, words
  localparam int K_W_DEF  = 7;      // Relative offset width

  // ==========================================================
  // Branch selector codes
  typedef enum logic [2:0] {
    branch_on_carry_clear  = 3'h0,
    branch_same_or_higher  = 3'h1,
    branch_lower           = 3'h2,
    branch_minus           = 3'h3,
    branch_plus            = 3'h4,
    branch_signed_ge       = 3'h5,
    branch_signed_lt       = 3'h6,
    branch_unused          = 3'h7
  } branch_op_t;

  // ==========================================================
  // Cycle counts per outcome
  localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CYC_TAKEN     = 2'h2;

  // Controller states, one-hot
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_jump = 2'h2
  } branch_state_t;

endpackage

//--- core/branch_cond_eval.sv
// Condition test for the conditional relative branches.
// Pure combinational; the caller registers the result.
module branch_cond_eval
  import branch_pkg::*;
(
  input  wire branch_op_t op,
  input  wire logic       flag_c,
  input  wire logic       flag_n,
  input  wire logic       flag_v,
  output logic            take,
  output logic            legal
);

  // ==========================================================
  // Condition decode
  logic signed_lt;

  // Signed compare outcome is N xor V
  assign signed_lt = flag_n ^ flag_v;

  // One term per branch selector
  always_comb begin
    take  = 1'b0;
    legal = 1'b1;
    case (op)
      branch_on_carry_clear: take = ~flag_c;
      branch_same_or_higher: take = ~flag_c;
      branch_lower:          take = flag_c;
      branch_minus:          take = flag_n;
      branch_plus:           take = ~flag_n;
      branch_signed_ge:      take = ~signed_lt;
      branch_signed_lt:      take = signed_lt;
      default: begin
        take  = 1'b0;
        legal = 1'b0;
      end
    endcase
  end

endmodule

//--- sim/branch_unit_props.sv
// Port checker for the conditional branch unit.
// Bound onto the unit from the testbench top; sees its ports only.
module branch_unit_props
  import branch_pkg::*;
#(
  parameter int PC_W = PC_W_DEF,
  parameter int K_W  = K_W_DEF
)(
  input wire logic            mclk,
  input wire logic            srst,
  input wire logic            req,
  input wire branch_op_t      op,
  input wire logic [K_W-1:0]  offset,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0]      sreg,
  input wire logic            flag_c,
  input wire logic            flag_n,
  input wire logic            flag_v,
  input wire logic            busy_q,
  input wire logic            done_q,
  input wire logic            taken_q,
  input wire logic            illegal_q,
  input wire logic            pc_load_q,
  input wire logic [PC_W-1:0] pc_next_q,
  input wire logic [1:0]      cycles_q,
  input wire logic [7:0]      sreg_out_q
);
  // ========================================
  // Accepted request and its jump target
  logic            acc;
  logic [PC_W-1:0] tgt;
  assign acc = req && !busy_q;
  assign tgt = pc + {{(PC_W-K_W){offset[K_W-1]}}, offset} + 1'b1;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Busy in the second cycle shows a taken branch
  property p_cc; acc && (op == branch_on_carry_clear ||
    op == branch_same_or_higher) |=> busy_q == !$past(flag_c); endproperty
  a_cc: assert property (p_cc) else $error("carry clear");
  property p_lo; acc && op == branch_lower |=> busy_q == $past(flag_c);
  endproperty
  a_lo: assert property (p_lo) else $error("lower");
  property p_mi; acc && op == branch_minus |=> busy_q == $past(flag_n);
  endproperty
  a_mi: assert property (p_mi) else $error("minus");
  property p_pl; acc && op == branch_plus |=> busy_q == !$past(flag_n);
  endproperty
  a_pl: assert property (p_pl) else $error("plus");
  property p_ge; acc && op == branch_signed_ge
    |=> busy_q != ($past(flag_n) ^ $past(flag_v)); endproperty
  a_ge: assert property (p_ge) else $error("signed ge");
  property p_lt; acc && op == branch_signed_lt
    |=> busy_q == ($past(flag_n) ^ $past(flag_v)); endproperty
  a_lt: assert property (p_lt) else $error("signed lt");
  // Cycle count follows outcome; a wrong count hides a lost cycle
  property p_cy; done_q |-> cycles_q == {taken_q, !taken_q}
    && $past(busy_q) == taken_q; endproperty
  a_cy: assert property (p_cy) else $error("cycle count");
  // The PC load pulse and the completion pulse are one event
  property p_ld; pc_load_q == done_q; endproperty
  a_ld: assert property (p_ld) else $error("load pulse");
  // Busy never lasts two cycles: a request in it is refused
  property p_rf; busy_q |=> !busy_q; endproperty
  a_rf: assert property (p_rf) else $error("busy twice");
  // Unused selector: one cycle, flagged, never taken
  property p_un; acc && op == branch_unused
    |=> done_q && illegal_q && !taken_q; endproperty
  a_un: assert property (p_un) else $error("unused selector");
  property p_sr; acc |=> sreg_out_q == $past(sreg); endproperty
  a_sr: assert property (p_sr) else $error("status echo");
  // Fall-through lands on the next word
  property p_nt; done_q && !taken_q |-> pc_next_q == $past(pc) + 1'b1;
  endproperty
  a_nt: assert property (p_nt) else $error("fall through");
  property p_tg; done_q && taken_q |-> pc_next_q == $past(tgt, 2);
  endproperty
  a_tg: assert property (p_tg) else $error("jump target");
endmodule

//--- sim/conditional_branch_unit_test.sv
// Self-checking testbench for the conditional branch unit.
// Drives the unit's ports directly; default widths 16 and 7.
module conditional_branch_unit_test import branch_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, srst, req, flag_c, flag_n, flag_v;
  branch_op_t  op;
  logic [6:0]  offset;
  logic [15:0] pc, pc_next_q;
  logic [7:0]  sreg, sreg_out_q;
  logic [1:0]  cycles_q;
  logic        busy_q, done_q, taken_q, illegal_q, pc_load_q;
  int          mismatches = 0, num_checks = 0, ticks = 0;

  conditional_branch_unit u_dut (
    .mclk       (mclk),
    .srst       (srst),
    .req        (req),
    .op         (op),
    .offset     (offset),
    .pc         (pc),
    .sreg       (sreg),
    .flag_c     (flag_c),
    .flag_n     (flag_n),
    .flag_v     (flag_v),
    .busy_q     (busy_q),
    .done_q     (done_q),
    .taken_q    (taken_q),
    .illegal_q  (illegal_q),
    .pc_load_q  (pc_load_q),
    .pc_next_q  (pc_next_q),
    .cycles_q   (cycles_q),
    .sreg_out_q (sreg_out_q)
  );

  // ========================================
  // Clock, and a cycle ceiling against hangs
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 2000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(logic ok, string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  // One request; taken waits the extra busy cycle before judging
  task automatic run(branch_op_t o, logic [2:0] f, logic [6:0] k,
                     logic [15:0] p, logic t);
    logic [15:0] exp_pc;
    exp_pc = t ? p + {{9{k[6]}}, k} + 16'h1 : p + 16'h1;
    req <= 1'b1;
    op <= o;
    {flag_c, flag_n, flag_v} <= f;
    offset <= k;
    pc <= p;
    sreg <= {f, 5'h15};
    @(posedge mclk);
    req <= 1'b0;
    if (t) @(posedge mclk);
    @(negedge mclk);
    chk(done_q && pc_load_q && taken_q === t, "outcome");
    chk(cycles_q === (t ? CYC_TAKEN : CYC_NOT_TAKEN), "cycles");
    chk(illegal_q === (o == branch_unused), "unused flag");
    chk(pc_next_q === exp_pc, "next pc");
    chk(sreg_out_q === {f, 5'h15}, "status echo");
    @(posedge mclk);
  endtask

  // ========================================
  // Scenarios
  task automatic t_carry();
    run(branch_on_carry_clear, 3'b000, 7'h05, 16'h1000, 1'b1);
    run(branch_on_carry_clear, 3'b111, 7'h05, 16'h1000, 1'b0);
    run(branch_same_or_higher, 3'b011, 7'h3f, 16'h1000, 1'b1);
    run(branch_same_or_higher, 3'b100, 7'h3f, 16'h1000, 1'b0);
    run(branch_lower, 3'b100, 7'h7f, 16'h0000, 1'b1);
    run(branch_lower, 3'b011, 7'h7f, 16'h0000, 1'b0);
  endtask
  task automatic t_sign();
    run(branch_minus, 3'b010, 7'h3f, 16'hfff0, 1'b1);
    run(branch_minus, 3'b101, 7'h3f, 16'hfff0, 1'b0);
    run(branch_plus, 3'b101, 7'h40, 16'h0050, 1'b1);
    run(branch_plus, 3'b010, 7'h40, 16'hffff, 1'b0);
  endtask
  task automatic t_signed();
    logic [1:0] nv;
    for (int i = 0; i < 4; i++) begin
      nv = i[1:0];
      run(branch_signed_ge, {1'b0, nv}, 7'h40, 16'h0050, ~^nv);
      run(branch_signed_lt, {1'b1, nv}, 7'h01, 16'h0050, ^nv);
    end
  endtask
  // An unused selector finishes in one cycle as a flagged fall-through
  task automatic t_unused();
    run(branch_unused, 3'b000, 7'h10, 16'h0300, 1'b0);
  endtask
  // A request held through the busy cycle must be ignored
  task automatic t_refused();
    run(branch_on_carry_clear, 3'b000, 7'h3f, 16'h0200, 1'b1);
    req <= 1'b1;
    @(posedge mclk);
    op <= branch_minus;
    @(posedge mclk);
    req <= 1'b0;
    @(negedge mclk);
    chk(done_q === 1'b1 && taken_q === 1'b1, "taken done");
    @(negedge mclk);
    chk(done_q === 1'b0 && busy_q === 1'b0, "refused req");
    chk(pc_next_q === 16'h0240, "refused pc");
    @(posedge mclk);
  endtask

  initial begin
    srst = 1'b1;
    req = 1'b0;
    op = branch_on_carry_clear;
    offset = 7'h00;
    pc = 16'h0000;
    sreg = 8'h00;
    {flag_c, flag_n, flag_v} = 3'b000;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_carry();
    t_sign();
    t_signed();
    t_unused();
    t_refused();
    print_verdict();
  end
endmodule

bind conditional_branch_unit branch_unit_props #(.PC_W(PC_W), .K_W(K_W))
  u_props (
    .mclk       (mclk),
    .srst       (srst),
    .req        (req),
    .op         (op),
    .offset     (offset),
    .pc         (pc),
    .sreg       (sreg),
    .flag_c     (flag_c),
    .flag_n     (flag_n),
    .flag_v     (flag_v),
    .busy_q     (busy_q),
    .done_q     (done_q),
    .taken_q    (taken_q),
    .illegal_q  (illegal_q),
    .pc_load_q  (pc_load_q),
    .pc_next_q  (pc_next_q),
    .cycles_q   (cycles_q),
    .sreg_out_q (sreg_out_q)
  );
